// [logic/fcs_setup.sv]
// coupler start-up selector decode, parameter store and backplane sizing
`timescale 1ns/1ps
`include "fcs_defines.svh"
module fcs_setup import fcs_pkg::*; #(
	parameter int GROUPS = 8,
	parameter int GROUP_BYTES = 18,
	parameter int MAX_SLOTS = 32,
	parameter int FIFO_DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] selector_i,
	input wire logic [1:0] nv_rate_i,
	input wire logic nv_done_i,
	input wire logic nv_ok_i,
	output logic nv_wr_o,
	output logic [1:0] nv_rate_o,
	input wire logic dup_addr_i,
	output logic net_enable_o,
	output logic [5:0] node_addr_o,
	output logic [1:0] rate_o,
	input wire logic prm_wr_i,
	input wire logic prm_rd_i,
	input wire logic [3:0] prm_grp_i,
	input wire logic [4:0] prm_idx_i,
	input wire logic [7:0] prm_wdata_i,
	output logic [7:0] prm_rdata_o,
	output logic prm_rvalid_o,
	input wire logic prm_commit_i,
	output logic configured_o,
	output logic param_err_o,
	output logic det_req_o,
	output logic [5:0] det_slot_o,
	input wire logic det_ack_i,
	input wire logic det_present_i,
	input wire logic [7:0] det_in_i,
	input wire logic [7:0] det_out_i,
	output logic map_valid_o,
	output logic [5:0] map_slot_o,
	output logic [12:0] map_in_ofs_o,
	output logic [12:0] map_out_ofs_o,
	output logic sizes_valid_o,
	output logic [12:0] in_total_o,
	output logic [12:0] out_total_o,
	output logic fwd_valid_o,
	output logic [7:0] fwd_slot_o,
	output logic [7:0] fwd_data_o,
	output logic fwd_last_o,
	input wire logic fwd_ready_i,
	output logic fault_led_o,
	output logic supply_ok_led_o,
	output logic ready_led_o
);
	localparam int MEM_BYTES = GROUPS * GROUP_BYTES;
	localparam logic [7:0] MAX_LEN = 8'(GROUP_BYTES - 2);
	if (GROUPS < 1 || GROUPS > 8) $error("groups must be 1 to 8");
	if (GROUP_BYTES < 3 || GROUP_BYTES > 32) $error("group size must be 3 to 32");
	if (MAX_SLOTS < 1 || MAX_SLOTS > 32) $error("slots must be 1 to 32");

	// flat byte index of entry i of zero-based group g
	function automatic logic [7:0] fcs_index(input logic [3:0] g, input logic [4:0] i);
		fcs_index = 8'(32'(g) * GROUP_BYTES + 32'(i));
	endfunction : fcs_index

	// ************************************************************
	// selector decode
	// ************************************************************
	fcs_state_t st_r;
	logic [7:0] sel_r;
	wire sel_is_addr = sel_r <= `FCS_SEL_ADDR_MAX;
	wire sel_is_125 = sel_r == `FCS_SEL_RATE_125;
	wire sel_is_250 = sel_r == `FCS_SEL_RATE_250;
	wire sel_is_500 = sel_r == `FCS_SEL_RATE_500;
	wire sel_is_rate = sel_is_125 | sel_is_250 | sel_is_500;
	wire [1:0] sel_rate = sel_is_125 ? FCS_R125 : (sel_is_250 ? FCS_R250 : FCS_R500);

	// ************************************************************
	// parameter store
	// ************************************************************
	logic [7:0] mem [MEM_BYTES];
	wire [3:0] host_g = prm_grp_i - 4'h1;
	wire host_ok = prm_grp_i != 4'h0 && 32'(prm_grp_i) <= GROUPS && 32'(prm_idx_i) < GROUP_BYTES;
	wire [7:0] host_a = fcs_index(host_g, prm_idx_i);
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			for (int k = 0; k < MEM_BYTES; k++)
			begin
				mem[k] <= `FCS_LEN_UNUSED;
			end
		end
		else if (prm_wr_i && host_ok)
		begin
			mem[host_a] <= prm_wdata_i;
		end
	end
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			prm_rvalid_o <= 1'b0;
			prm_rdata_o <= 8'h00;
		end
		else
		begin
			prm_rvalid_o <= prm_rd_i & host_ok;
			prm_rdata_o <= host_ok ? mem[host_a] : 8'h00;
		end
	end

	// ************************************************************
	// forwarding path
	// ************************************************************
	logic [3:0] g_r;
	logic [4:0] p_r;
	wire [7:0] g_len = mem[fcs_index(g_r, `FCS_LEN_POS)];
	wire [7:0] g_slot = mem[fcs_index(g_r, `FCS_SLOT_POS)];
	wire [7:0] g_byte = mem[fcs_index(g_r, `FCS_DATA_POS + p_r)];
	wire g_unused = g_len == `FCS_LEN_UNUSED;
	wire g_oversize = g_len > MAX_LEN;
	wire g_last = {3'h0, p_r} == 8'(g_len - 8'h01);
	wire g_final = 32'(g_r) == GROUPS - 1;
	wire fi_valid = st_r == FCS_FWD && !g_unused && !g_oversize;
	wire fi_ready;
	wire fo_valid;
	wire [16:0] fo_data;
	wire fo_ready = !fwd_valid_o || fwd_ready_i;
	fcs_fifo #(.WIDTH(17), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.in_valid_i(fi_valid),
		.in_ready_o(fi_ready),
		.in_data_i({g_last, g_slot, g_byte}),
		.out_valid_o(fo_valid),
		.out_ready_i(fo_ready),
		.out_data_o(fo_data)
	);
	// output stage keeps the fifo's read mux off the pins
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			fwd_valid_o <= 1'b0;
			{fwd_last_o, fwd_slot_o, fwd_data_o} <= 17'h00000;
		end
		else if (fo_ready)
		begin
			fwd_valid_o <= fo_valid;
			{fwd_last_o, fwd_slot_o, fwd_data_o} <= fo_data;
		end
	end

	// ************************************************************
	// sequencing
	// ************************************************************
	logic commit_pend_r;
	// a commit during scan or forwarding is remembered, set beats clear
	wire commit_take = st_r == FCS_RUN;
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			commit_pend_r <= 1'b0;
		end
		else
		begin
			commit_pend_r <= prm_commit_i | (commit_pend_r & !commit_take);
		end
	end
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			st_r <= FCS_BOOT;
			sel_r <= 8'h00;
			nv_wr_o <= 1'b0;
			nv_rate_o <= 2'h0;
			net_enable_o <= 1'b0;
			node_addr_o <= 6'h00;
			rate_o <= 2'h0;
			configured_o <= 1'b0;
			param_err_o <= 1'b0;
			det_req_o <= 1'b0;
			det_slot_o <= `FCS_FIRST_SLOT;
			map_valid_o <= 1'b0;
			map_slot_o <= 6'h00;
			map_in_ofs_o <= 13'h0000;
			map_out_ofs_o <= 13'h0000;
			sizes_valid_o <= 1'b0;
			in_total_o <= 13'h0000;
			out_total_o <= 13'h0000;
			fault_led_o <= 1'b0;
			supply_ok_led_o <= 1'b0;
			ready_led_o <= 1'b0;
			g_r <= 4'h0;
			p_r <= 5'h00;
		end
		else
		begin
			supply_ok_led_o <= 1'b1;
			nv_wr_o <= 1'b0;
			map_valid_o <= 1'b0;
			if (net_enable_o && dup_addr_i)
			begin
				fault_led_o <= 1'b1;
			end
			case (st_r)
				FCS_BOOT:
				begin
					sel_r <= selector_i;
					rate_o <= nv_rate_i;
					st_r <= FCS_DECODE;
				end
				FCS_DECODE:
				begin
					if (sel_is_rate)
					begin
						nv_wr_o <= 1'b1;
						nv_rate_o <= sel_rate;
						st_r <= FCS_NVWR;
					end
					else if (sel_is_addr)
					begin
						net_enable_o <= 1'b1;
						node_addr_o <= sel_r[5:0];
						det_req_o <= 1'b1;
						st_r <= FCS_SCAN;
					end
					else
					begin
						fault_led_o <= 1'b1;
						st_r <= FCS_HALT;
					end
				end
				FCS_NVWR:
				begin
					if (nv_done_i)
					begin
						ready_led_o <= nv_ok_i;
						fault_led_o <= fault_led_o | !nv_ok_i;
						st_r <= FCS_HALT;
					end
				end
				FCS_SCAN:
				begin
					if (det_ack_i)
					begin
						map_valid_o <= det_present_i;
						map_slot_o <= det_slot_o;
						map_in_ofs_o <= in_total_o;
						map_out_ofs_o <= out_total_o;
						if (det_present_i)
						begin
							in_total_o <= in_total_o + {5'h00, det_in_i};
							out_total_o <= out_total_o + {5'h00, det_out_i};
						end
						if (32'(det_slot_o) == MAX_SLOTS)
						begin
							det_req_o <= 1'b0;
							sizes_valid_o <= 1'b1;
							ready_led_o <= 1'b1;
							st_r <= FCS_RUN;
						end
						else
						begin
							det_slot_o <= det_slot_o + 6'h01;
						end
					end
				end
				FCS_RUN:
				begin
					if (commit_pend_r)
					begin
						configured_o <= 1'b0;
						param_err_o <= 1'b0;
						g_r <= 4'h0;
						p_r <= 5'h00;
						st_r <= FCS_FWD;
					end
				end
				FCS_FWD:
				begin
					if (g_unused || g_oversize || (fi_ready && g_last))
					begin
						param_err_o <= param_err_o | (!g_unused && g_oversize);
						p_r <= 5'h00;
						g_r <= g_r + 4'h1;
						if (g_final)
						begin
							configured_o <= 1'b1;
							st_r <= FCS_RUN;
						end
					end
					else if (fi_ready)
					begin
						p_r <= p_r + 5'h01;
					end
				end
				FCS_HALT:
				begin
					st_r <= FCS_HALT;
				end
				default:
				begin
					st_r <= FCS_HALT;
				end
			endcase
		end
	end
endmodule : fcs_setup

// [logic/fcs_defines.svh]
// constants of the coupler start-up and configuration block
`ifndef FCS_DEFINES_SVH
`define FCS_DEFINES_SVH
`define FCS_SEL_ADDR_MAX 8'h3f
`define FCS_SEL_RATE_125 8'h5a
`define FCS_SEL_RATE_250 8'h5b
`define FCS_SEL_RATE_500 8'h5c
`define FCS_LEN_UNUSED 8'h00
`define FCS_LEN_POS 5'h00
`define FCS_SLOT_POS 5'h01
`define FCS_DATA_POS 5'h02
`define FCS_FIRST_SLOT 6'h01
`endif

// [logic/fcs_pkg.sv]
// types of the coupler start-up and configuration block
package fcs_pkg;
	typedef enum logic [6:0] {
		FCS_BOOT = 7'h01,
		FCS_DECODE = 7'h02,
		FCS_NVWR = 7'h04,
		FCS_SCAN = 7'h08,
		FCS_RUN = 7'h10,
		FCS_FWD = 7'h20,
		FCS_HALT = 7'h40
	} fcs_state_t;
	typedef enum logic [1:0] {
		FCS_R125 = 2'h0,
		FCS_R250 = 2'h1,
		FCS_R500 = 2'h2
	} fcs_rate_t;
endpackage : fcs_pkg

// [logic/fcs_fifo.sv]
// parameter forwarding fifo with valid/ready on both sides
`timescale 1ns/1ps
module fcs_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	wire push = in_valid_i & in_ready_o;
	wire pop = out_valid_o & out_ready_i;
	assign in_ready_o = cnt_r != (AW+1)'(DEPTH);
	assign out_valid_o = cnt_r != '0;
	assign out_data_o = mem[rp_r];
	always_ff @(posedge clk_i)
	begin
		if (push)
		begin
			mem[wp_r] <= in_data_i;
		end
	end
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end
		else
		begin
			wp_r <= wp_r + AW'(push);
			rp_r <= rp_r + AW'(pop);
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : fcs_fifo

// [tb/fcs_setup_properties.sv]
// port checker of the coupler setup block
`timescale 1ns/1ps
module fcs_setup_chk #(
	parameter int MAX_SLOTS = 32
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] selector_i,
	input wire logic nv_done_i,
	input wire logic nv_ok_i,
	input wire logic nv_wr_o,
	input wire logic [1:0] nv_rate_o,
	input wire logic dup_addr_i,
	input wire logic net_enable_o,
	input wire logic [5:0] node_addr_o,
	input wire logic prm_rd_i,
	input wire logic [3:0] prm_grp_i,
	input wire logic [4:0] prm_idx_i,
	input wire logic prm_rvalid_o,
	input wire logic det_req_o,
	input wire logic [5:0] det_slot_o,
	input wire logic det_ack_i,
	input wire logic det_present_i,
	input wire logic map_valid_o,
	input wire logic [5:0] map_slot_o,
	input wire logic [12:0] map_in_ofs_o,
	input wire logic [12:0] map_out_ofs_o,
	input wire logic [12:0] in_total_o,
	input wire logic [12:0] out_total_o,
	input wire logic fault_led_o,
	input wire logic ready_led_o
);
	// ****************
	// startup, scan and parameter reads
	// ****************
	logic rst_q_r;
	logic boot_w;
	always_ff @(posedge clk_i)
		rst_q_r <= sys_rst_i;
	// first edge out of reset is the only one that takes the selector
	assign boot_w = rst_q_r && !sys_rst_i;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	sequence s_nv_wait;
		nv_wr_o ##1 !nv_done_i ##1 nv_done_i;
	endsequence
	sequence s_ack;
		det_req_o && det_ack_i;
	endsequence
	AST_RATE_SEL: assert property (boot_w && selector_i inside {[8'h5a:8'h5c]} |-> ##2
		nv_wr_o && {6'h00, nv_rate_o} == $past(selector_i, 2) - 8'h5a) else $error("rate bad");
	AST_ADDR_SEL: assert property (boot_w && selector_i <= 8'h3f |-> ##2 net_enable_o &&
		!nv_wr_o && {2'h0, node_addr_o} == $past(selector_i, 2)) else $error("addr bad");
	AST_BAD_SEL: assert property (boot_w && !(selector_i inside {[8'h00:8'h3f],
		[8'h5a:8'h5c]}) |-> ##2 fault_led_o && !net_enable_o) else $error("bad sel");
	AST_NV_RESULT: assert property (s_nv_wait |=> ready_led_o == $past(nv_ok_i) &&
		fault_led_o != $past(nv_ok_i)) else $error("nv result bad");
	AST_DUP_FAULT: assert property (net_enable_o && dup_addr_i |-> ##[1:2] fault_led_o)
		else $error("dup not flagged");
	AST_MAP: assert property (s_ack ##0 det_present_i |=> map_valid_o &&
		map_slot_o == $past(det_slot_o) && map_in_ofs_o == $past(in_total_o) &&
		map_out_ofs_o == $past(out_total_o)) else $error("map");
	AST_SLOT_STEP: assert property (s_ack ##0 det_slot_o < 6'(MAX_SLOTS) |=>
		det_slot_o == $past(det_slot_o) + 6'h01) else $error("slot order");
	AST_RD: assert property (prm_rd_i && prm_grp_i inside {[4'h1:4'h8]} &&
		prm_idx_i < 5'h12 |=> prm_rvalid_o) else $error("read lost");
endmodule : fcs_setup_chk
bind fcs_setup fcs_setup_chk #(.MAX_SLOTS(MAX_SLOTS)) u_chk (.clk_i, .sys_rst_i, .selector_i,
	.nv_done_i, .nv_ok_i, .nv_wr_o, .nv_rate_o, .dup_addr_i, .net_enable_o, .node_addr_o,
	.prm_rd_i, .prm_grp_i, .prm_idx_i, .prm_rvalid_o, .det_req_o, .det_slot_o, .det_ack_i,
	.det_present_i, .map_valid_o, .map_slot_o, .map_in_ofs_o, .map_out_ofs_o, .in_total_o,
	.out_total_o, .fault_led_o,
	.ready_led_o);

// [tb/fcs_bp_model.sv]
// backplane stand-in: answers slot scans, takes forwarded bytes
`timescale 1ns/1ps
module fcs_bp_model (
	input wire logic clk_i,
	input wire logic det_req_i,
	input wire logic [5:0] det_slot_i,
	output logic det_ack_o,
	output logic det_present_o,
	output logic [7:0] det_in_o,
	output logic [7:0] det_out_o,
	input wire logic fwd_valid_i,
	input wire logic [7:0] fwd_slot_i,
	input wire logic [7:0] fwd_data_i,
	input wire logic fwd_last_i,
	output logic fwd_ready_o = 1'h0,
	output logic [23:0] got_o = 24'h0,
	output logic [7:0] cnt_o = 8'h00,
	output logic [7:0] slot_o = 8'h00
);
	// ****************
	// answers
	// ****************
	initial
		det_ack_o = 1'h0;
	always @(posedge clk_i)
	begin
		det_ack_o <= det_req_i && !det_ack_o;
		// stalls every other cycle
		fwd_ready_o <= !fwd_ready_o;
		if (fwd_valid_i && fwd_ready_o)
		begin
			got_o <= {got_o[15:0], fwd_data_i};
			cnt_o <= cnt_o + 8'h01;
			slot_o <= fwd_last_i ? fwd_slot_i : 8'hee;
		end
	end
	// modules in slots 1 to 3 only; lines carry junk outside an answer
	assign det_present_o = det_ack_o && det_slot_i < 6'h04;
	assign det_in_o = det_ack_o ? {2'h0, det_slot_i} : ~{2'h0, det_slot_i};
	assign det_out_o = det_ack_o ? 8'h01 : 8'hfe;
endmodule : fcs_bp_model

// [tb/tb.sv]
// self-checking bench of the coupler setup block
`timescale 1ns/1ps
module tb;
	logic clk_i = 1'h0, sys_rst_i = 1'h1, nv_done_i = 1'h0, nv_ok_i = 1'h0, dup_addr_i = 1'h0;
	logic prm_wr_i = 1'h0, prm_rd_i = 1'h0, prm_commit_i = 1'h0, nv_wr_o, net_enable_o;
	logic prm_rvalid_o, configured_o, param_err_o, det_req_o, det_ack_i, det_present_i;
	logic map_valid_o, sizes_valid_o, fwd_valid_o, fwd_last_o, fwd_ready_i, fault_led_o;
	logic supply_ok_led_o, ready_led_o;
	logic [7:0] selector_i = 8'h00, prm_wdata_i = 8'h00, prm_rdata_o, det_in_i, det_out_i;
	logic [7:0] fwd_slot_o, fwd_data_o, cnt, last_slot;
	logic [1:0] nv_rate_i = 2'h1, nv_rate_o, rate_o;
	logic [3:0] prm_grp_i = 4'h0;
	logic [4:0] prm_idx_i = 5'h00;
	logic [5:0] node_addr_o, det_slot_o, map_slot_o;
	logic [12:0] map_in_ofs_o, map_out_ofs_o, in_total_o, out_total_o;
	logic [23:0] got;
	logic [7:0] rsel [4] = '{8'h5a, 8'h5b, 8'h5c, 8'h60};
	logic [16:0] wt [8] = '{{4'h1, 5'h00, 8'h03}, {4'h1, 5'h01, 8'h02}, {4'h1, 5'h02, 8'h11},
		{4'h1, 5'h03, 8'h22}, {4'h1, 5'h04, 8'h44}, {4'h1, 5'h05, 8'hff},
		{4'h2, 5'h01, 8'h04}, {4'h3, 5'h00, 8'h11}};
	int fail_count = 0;
	int tests_run = 0;
	int n;
	always #50 clk_i = ~clk_i;
	fcs_setup dut (.clk_i, .sys_rst_i, .selector_i, .nv_rate_i, .nv_done_i, .nv_ok_i, .nv_wr_o,
		.nv_rate_o, .dup_addr_i, .net_enable_o, .node_addr_o, .rate_o, .prm_wr_i, .prm_rd_i,
		.prm_grp_i, .prm_idx_i, .prm_wdata_i, .prm_rdata_o, .prm_rvalid_o, .prm_commit_i,
		.configured_o, .param_err_o, .det_req_o, .det_slot_o, .det_ack_i, .det_present_i,
		.det_in_i, .det_out_i, .map_valid_o, .map_slot_o, .map_in_ofs_o, .map_out_ofs_o,
		.sizes_valid_o, .in_total_o, .out_total_o, .fwd_valid_o, .fwd_slot_o, .fwd_data_o,
		.fwd_last_o, .fwd_ready_i, .fault_led_o, .supply_ok_led_o, .ready_led_o);
	fcs_bp_model bp (.clk_i, .det_req_i(det_req_o), .det_slot_i(det_slot_o), .det_ack_o(det_ack_i),
		.det_present_o(det_present_i), .det_in_o(det_in_i), .det_out_o(det_out_i),
		.fwd_valid_i(fwd_valid_o), .fwd_slot_i(fwd_slot_o), .fwd_data_i(fwd_data_o),
		.fwd_last_i(fwd_last_o), .fwd_ready_o(fwd_ready_i), .got_o(got), .cnt_o(cnt),
		.slot_o(last_slot));
	// ****************
	// access tasks
	// ****************
	task tick;
		@(posedge clk_i);
		#1;
	endtask : tick
	task chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
		tests_run++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : chk
	task end_of_test;
		$display("checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test
	task guard(input logic ok, input string what);
		chk(ok, 24'h1, what);
		if (ok !== 1'h1)
			end_of_test;
	endtask : guard
	task boot(input logic [7:0] sel);
		sys_rst_i = 1'h1;
		selector_i = sel;
		repeat (12) tick;
		sys_rst_i = 1'h0;
		repeat (2) tick;
	endtask : boot
	task prm(input logic wr, input logic [3:0] g, input logic [4:0] i, input logic [7:0] d);
		// strobe stays up into the next call, so no signal is set twice in one step
		prm_wr_i = wr;
		prm_rd_i = !wr;
		prm_grp_i = g;
		prm_idx_i = i;
		prm_wdata_i = d;
		tick;
	endtask : prm
	// ****************
	// sequence
	// ****************
	initial
	begin
		foreach (rsel[k])
		begin
			boot(rsel[k]);
			if (k < 3)
			begin
				chk(nv_wr_o, 24'h1, "nv write");
				chk(nv_rate_o, k, "nv rate");
				nv_ok_i = (k != 2);
				repeat (2) tick;
				nv_done_i = 1'h1;
				tick;
				nv_done_i = 1'h0;
				tick;
				chk(ready_led_o, nv_ok_i, "green led");
				chk(fault_led_o, !nv_ok_i, "fault led");
			end
			else
			begin
				chk(fault_led_o, 24'h1, "fault led");
				chk(net_enable_o, 24'h0, "net enable");
			end
		end
		boot(8'h3f);
		// moved after sampling, must have no effect
		selector_i = 8'h05;
		chk(net_enable_o, 24'h1, "net enable");
		chk(nv_wr_o, 24'h0, "nv write");
		chk(rate_o, 24'h1, "rate");
		chk(supply_ok_led_o, 24'h1, "supply led");
		foreach (wt[j])
			prm(1'h1, wt[j][16:13], wt[j][12:8], wt[j][7:0]);
		prm(1'h1, 4'h8, 5'h11, 8'h5c);
		prm(1'h0, 4'h8, 5'h11, 8'h00);
		chk(prm_rdata_o, 24'h5c, "last entry");
		prm(1'h0, 4'h1, 5'h05, 8'h00);
		chk(prm_rvalid_o, 24'h1, "read valid");
		chk(prm_rdata_o, 24'hff, "read data");
		prm(1'h0, 4'h9, 5'h00, 8'h00);
		chk(prm_rvalid_o, 24'h0, "bad group read");
		prm_rd_i = 1'h0;
		for (n = 0; n < 500 && sizes_valid_o !== 1'h1; n++)
			tick;
		guard(sizes_valid_o, "scan done");
		chk(in_total_o, 24'h6, "input total");
		chk(out_total_o, 24'h3, "output total");
		chk(node_addr_o, 24'h3f, "node addr");
		prm_commit_i = 1'h1;
		tick;
		prm_commit_i = 1'h0;
		for (n = 0; n < 500 && cnt !== 8'h03; n++)
			tick;
		guard(cnt === 8'h03, "forward count");
		repeat (40) tick;
		chk(cnt, 24'h3, "forwarded bytes");
		chk(got, 24'h112244, "forward order");
		chk(last_slot, 24'h2, "target slot");
		chk(configured_o, 24'h1, "configured");
		chk(param_err_o, 24'h1, "length error");
		chk(fault_led_o, 24'h0, "fault led");
		dup_addr_i = 1'h1;
		repeat (2) tick;
		chk(fault_led_o, 24'h1, "fault led");
		end_of_test;
	end
endmodule : tb
